// ---- src/psts_sequencer.v ----
// Power-state slot sequencer: runs ON, OFF, SLEEP and WAKE sequences
// over five timed slots and keeps the power-state registers.
// Assumes an Avalon-MM master on mclk and synchronous event inputs.
//
// Notes on behaviour
// R1: Transitions other than OFF from SLEEP run five consecutive slots of 2 ms each.
// R2: ON slot stretches until every circuit enabled in it reports good.
// R3: OFF, SLEEP and WAKE start after the programmed transition delay.
// R4: Delay codes 00 and 01 none, 10 one ms, 11 ten ms; reset 10.
// R5: Each item except the fourth converter takes one ON slot.
// R6: Clock output and external enable also take ON and SLEEP slots.
// R7: ON starts only while supply is above the good threshold.
// R8: OFF switches ON-slot items off in reverse slot order.
// R9: ON slots may change in ON; OFF uses the current ones.
// R10: SLEEP disables each item except the fourth converter at its SLEEP slot.
// R11: WAKE re-enables SLEEP-slot items in reverse order.
// R12: SLEEP slots may change in SLEEP; WAKE uses the current ones.
// R13: Items without ON slot may follow a hardware enable pin.
// R14: In ON, items not pin-controlled are switchable by software.
// R15: OFF disables unslotted items at once, except kept always-on one.
// R16: ON unfinished after two seconds flags failure and forces OFF.
// R17: Sequence failure disables everything immediately.
// R18: Source registers change only on a new event of their kind.
// R19: Reset-driven OFF then ON records a reset cause.
// R20: System-on bit 15 shows ON or SLEEP; writing 0 requests OFF.
// R21: Sleep bit 14 shows SLEEP; 1 requests SLEEP, 0 requests WAKE.
// R22: On/wake source holds type bit 15 and cause flags 11, 10, 8 to 4 and 1.
// R23: Low supply may wake, recorded at bit 10, but never turns ON.
// R24: Main state reads 00 OFF, 10 in transition, 1C SLEEP, 1F ON.
// R25: OFF in SLEEP disables everything but a kept always-on item at once, no slot sequence.
// R26: Slot timer runs on mclk; requests wait for the running sequence.
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "psts_map.vh"

module psts_sequencer #(
  parameter N_ITEM = `PS_N_ITEM,
  parameter [23:0] SLOT_CYC = `PS_SLOT_US * `PS_MCLK_MHZ,
  parameter [23:0] DLY1_CYC = `PS_DLY1_US * `PS_MCLK_MHZ,
  parameter [23:0] DLY10_CYC = `PS_DLY10_US * `PS_MCLK_MHZ,
  parameter [25:0] FAIL_CYC = `PS_FAIL_US * `PS_MCLK_MHZ
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Avalon-MM slave, byte address
  input wire [17:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Events and supply status
  input wire ev_on_pin,
  input wire ev_on_gpio,
  input wire ev_rtc_alarm,
  input wire ev_charger,
  input wire ev_watchdog,
  input wire ev_low_supply,
  input wire ev_off_pin,
  input wire ev_off_gpio,
  input wire ev_reset,
  input wire supply_good,
  // Item power-good and hardware enable pins
  input wire [N_ITEM-1:0] power_good,
  input wire [N_ITEM-1:0] hw_enable_in,
  // Item enables; top two are clock output and external enable
  output wire [N_ITEM-1:0] item_en,
  output wire [4:0] main_state,
  output wire seq_fail
);

  localparam [4:0] S_OFF = 5'b00001;
  localparam [4:0] S_DLY = 5'b00010;
  localparam [4:0] S_SEQ = 5'b00100;
  localparam [4:0] S_ON = 5'b01000;
  localparam [4:0] S_SLP = 5'b10000;

  reg [4:0] st_q;
  reg [1:0] kind_q;
  reg [2:0] slot_q;
  reg [23:0] tmr_q;
  reg [25:0] fail_q;
  reg [N_ITEM-1:0] en_q;
  reg [4:0] ms_q;
  reg seq_fail_q;
  reg wait_q;
  reg [31:0] rdata_q;
  reg [1:0] dly_sel_q;
  reg aon_keep_q;
  reg [31:0] on_slot_q;
  reg [31:0] slp_slot_q;
  reg [N_ITEM-1:0] hw_sel_q;
  reg [15:0] onsrc_q;
  reg [15:0] offsrc_q;
  reg pw_q;
  reg po_q;
  reg ps_q;
  reg rst_q;
  reg [15:0] wc_q;
  reg [15:0] oc_q;

  wire [15:0] idx = avs_address[17:2];
  wire wr_go = avs_write & ~wait_q;
  wire wr_ctl = wr_go & (idx == `PS_IX_CTL);
  wire wr_swen = wr_go & (idx == `PS_IX_SWEN);
  wire sw_off = wr_ctl & ~avs_writedata[`PS_B_SYSON]; // see R20
  wire sw_slp = wr_ctl & avs_writedata[`PS_B_SLEEP]; // see R21
  wire sw_wake = wr_ctl & ~avs_writedata[`PS_B_SLEEP]; // see R21

  // Per-item slot decode
  wire [N_ITEM-1:0] mon;
  wire [N_ITEM-1:0] msl;
  wire [N_ITEM-1:0] non;
  wire [N_ITEM-1:0] offnow;
  genvar gi;
  generate
    for (gi = 0; gi < N_ITEM; gi = gi + 1) begin : g_item
      wire [2:0] fon = on_slot_q[gi*`PS_SLOT_W +: `PS_SLOT_W];
      wire [2:0] fsl = slp_slot_q[gi*`PS_SLOT_W +: `PS_SLOT_W];
      wire fourth = (gi == `PS_FOURTH_IDX);
      // Fourth converter never sequenced; software, or its hardware pin when selected in hw_sel_q, owns it
      assign mon[gi] = ~fourth & (fon == slot_q); // see R5 R6
      assign msl[gi] = ~fourth & (fsl == slot_q); // see R10 R6
      assign non[gi] = fourth | (fon == `PS_SLOT_NONE);
      assign offnow[gi] = non[gi] &
        ~((gi == `PS_AON_IDX) & aon_keep_q); // see R15
    end
  endgenerate

  // Event collection
  wire [15:0] wset =
    (ev_on_pin ? `PS_OW_PIN : 16'h0000) |
    (ev_on_gpio ? `PS_OW_GPIO : 16'h0000) |
    (ev_rtc_alarm ? `PS_OW_RTC : 16'h0000) |
    (ev_charger ? `PS_OW_CHG : 16'h0000) |
    (ev_watchdog ? `PS_OW_WDOG : 16'h0000) |
    (ev_low_supply ? `PS_OW_LOW_SUPPLY_THRESHOLD : 16'h0000) |
    (sw_wake ? `PS_OW_SW : 16'h0000);
  wire [15:0] oset =
    (ev_off_pin ? `PS_OF_PIN : 16'h0000) |
    (ev_off_gpio ? `PS_OF_GPIO : 16'h0000) |
    (sw_off ? `PS_OF_SW : 16'h0000);

  wire st_off = st_q[0];
  wire st_on = st_q[3];
  wire st_slp = st_q[4];
  // Low supply is absent from the ON cause mask
  wire has_on = |(wc_q & `PS_OW_ONC) | rst_q; // see R23
  wire go_on = st_off & (pw_q | rst_q) & has_on & supply_good; // see R7
  wire go_off = st_on & po_q;
  wire go_slp = st_on & ~po_q & ps_q;
  wire go_kill = st_slp & po_q;
  wire go_wake = st_slp & ~po_q & pw_q;
  // Requests only clear in a settled state, so they wait out a sequence
  wire pw_clr = go_on | (st_off & ~has_on) | st_on | go_wake | go_kill; // see R26
  wire po_clr = go_off | go_kill | st_off;
  wire ps_clr = go_slp | st_off | st_slp;

  // Software control of items not pin-controlled, hardware-pin control of unsequenced items
  wire [N_ITEM-1:0] hwc = hw_sel_q & non;
  wire [N_ITEM-1:0] en_hw = (en_q & ~hwc) | (hw_enable_in & hwc); // see R13
  wire [N_ITEM-1:0] en_sw = wr_swen ?
    ((avs_writedata[N_ITEM-1:0] & ~hwc) | (hw_enable_in & hwc)) :
    en_hw; // see R14

  reg [23:0] dly_cyc;
  reg [N_ITEM-1:0] en_act;
  reg [31:0] rd_mux;
  always @* begin
    case (dly_sel_q) // see R4
      `PS_DLY_1MS: dly_cyc = DLY1_CYC;
      `PS_DLY_10MS: dly_cyc = DLY10_CYC;
      default: dly_cyc = 24'h000000;
    endcase
    case (kind_q)
      `PS_K_ON: en_act = en_q | mon; // see R5
      `PS_K_OFF: en_act = en_q & ~mon; // see R8 R9
      `PS_K_SLP: en_act = en_q & ~msl; // see R10
      default: en_act = en_q | msl; // see R11 R12
    endcase
    rd_mux = 32'h00000000;
    case (idx)
      `PS_IX_CTL: begin
        rd_mux[`PS_B_SYSON] = st_on | st_slp; // see R20
        rd_mux[`PS_B_SLEEP] = st_slp; // see R21
        rd_mux[`PS_F_DLY] = dly_sel_q;
        rd_mux[`PS_B_AONKEEP] = aon_keep_q;
      end
      `PS_IX_STAT: rd_mux[4:0] = ms_q; // see R24
      `PS_IX_ONSRC: rd_mux[15:0] = onsrc_q; // see R22
      `PS_IX_OFFSRC: rd_mux[15:0] = offsrc_q;
      `PS_IX_ONSLOT: rd_mux = on_slot_q;
      `PS_IX_SLPSLOT: rd_mux = slp_slot_q;
      `PS_IX_SWEN: rd_mux[N_ITEM-1:0] = en_q;
      `PS_IX_HWSEL: rd_mux[N_ITEM-1:0] = hw_sel_q;
      default: rd_mux = 32'h00000000;
    endcase
  end

  wire rev = (kind_q == `PS_K_OFF) | (kind_q == `PS_K_WK);
  wire last = rev ? (slot_q == `PS_SLOT_FIRST) : (slot_q == `PS_SLOT_LAST);
  wire pg_ok = &(~mon | power_good);
  wire slot_end = (tmr_q >= SLOT_CYC - 24'h000001);
  wire is_on = (kind_q == `PS_K_ON);

  // Bus slave: one wait cycle, then the request completes
  always @(posedge mclk) begin
    if (!rst_b) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
      if (avs_read & wait_q) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Configuration registers and pending requests
  always @(posedge mclk) begin
    if (!rst_b) begin
      dly_sel_q <= `PS_DLY_RST; // see R4
      aon_keep_q <= 1'b0;
      on_slot_q <= 32'h00000000;
      slp_slot_q <= 32'h00000000;
      hw_sel_q <= {N_ITEM{1'b0}};
      pw_q <= 1'b0;
      po_q <= 1'b0;
      ps_q <= 1'b0;
      rst_q <= 1'b0;
      wc_q <= 16'h0000;
      oc_q <= 16'h0000;
    end else begin
      if (wr_ctl) begin
        dly_sel_q <= avs_writedata[`PS_F_DLY];
        aon_keep_q <= avs_writedata[`PS_B_AONKEEP];
      end
      // Slot maps are live, so edits change the next reverse sequence
      if (wr_go & (idx == `PS_IX_ONSLOT)) begin
        on_slot_q <= avs_writedata; // see R9
      end
      if (wr_go & (idx == `PS_IX_SLPSLOT)) begin
        slp_slot_q <= avs_writedata; // see R12
      end
      if (wr_go & (idx == `PS_IX_HWSEL)) begin
        hw_sel_q <= avs_writedata[N_ITEM-1:0];
      end
      // A new event in the clearing cycle survives
      pw_q <= (pw_q & ~pw_clr) | (|wset);
      wc_q <= (pw_clr ? 16'h0000 : wc_q) | wset;
      po_q <= (po_q & ~po_clr) | (|oset) | (ev_reset & ~st_off);
      oc_q <= (po_clr ? 16'h0000 : oc_q) | oset;
      ps_q <= (ps_q & ~ps_clr) | sw_slp;
      rst_q <= (rst_q & ~go_on) | ev_reset; // see R19
    end
  end

  // Sequencer
  always @(posedge mclk) begin
    if (!rst_b) begin
      st_q <= S_OFF;
      kind_q <= `PS_K_ON;
      slot_q <= `PS_SLOT_FIRST;
      tmr_q <= 24'h000000;
      fail_q <= 26'h0000000;
      en_q <= {N_ITEM{1'b0}};
      ms_q <= `PS_MS_OFF;
      seq_fail_q <= 1'b0;
      onsrc_q <= 16'h0000;
      offsrc_q <= 16'h0000;
    end else begin
      seq_fail_q <= 1'b0;
      case (st_q)
        S_OFF: begin
          ms_q <= `PS_MS_OFF;
          if (go_on) begin
            kind_q <= `PS_K_ON;
            slot_q <= `PS_SLOT_FIRST;
            tmr_q <= 24'h000000;
            fail_q <= 26'h0000000;
            st_q <= S_SEQ; // see R1
            ms_q <= `PS_MS_TRANS;
            onsrc_q <= (wc_q & `PS_OW_ONC) | `PS_OW_TRANS |
              (rst_q ? `PS_OW_RST : 16'h0000); // see R18 R19 R22
          end
        end
        S_ON: begin
          ms_q <= `PS_MS_ON;
          en_q <= en_sw;
          if (go_off) begin
            en_q <= en_sw & ~offnow; // see R15
            offsrc_q <= oc_q; // see R18
            kind_q <= `PS_K_OFF;
            tmr_q <= 24'h000000;
            st_q <= S_DLY;
            ms_q <= `PS_MS_TRANS;
          end else if (go_slp) begin
            kind_q <= `PS_K_SLP;
            tmr_q <= 24'h000000;
            st_q <= S_DLY;
            ms_q <= `PS_MS_TRANS;
          end
        end
        S_SLP: begin
          ms_q <= `PS_MS_SLEEP;
          en_q <= en_hw;
          if (go_kill) begin
            // No timed shutdown from SLEEP
            en_q <= en_hw & non & ~offnow; // see R25
            offsrc_q <= oc_q;
            st_q <= S_OFF;
            ms_q <= `PS_MS_OFF;
          end else if (go_wake) begin
            onsrc_q <= wc_q & `PS_OW_WKC; // see R18 R23
            kind_q <= `PS_K_WK;
            tmr_q <= 24'h000000;
            st_q <= S_DLY;
            ms_q <= `PS_MS_TRANS;
          end
        end
        S_DLY: begin
          if (tmr_q >= dly_cyc) begin
            st_q <= S_SEQ; // see R3
            tmr_q <= 24'h000000;
            slot_q <= rev ? `PS_SLOT_LAST : `PS_SLOT_FIRST; // see R8 R11
          end else begin
            tmr_q <= tmr_q + 24'h000001;
          end
        end
        S_SEQ: begin
          fail_q <= fail_q + 26'h0000001;
          if (is_on & (fail_q >= FAIL_CYC - 26'h0000001)) begin
            en_q <= {N_ITEM{1'b0}}; // see R16 R17
            seq_fail_q <= 1'b1;
            offsrc_q <= `PS_OF_SEQ; // see R16
            st_q <= S_OFF;
            ms_q <= `PS_MS_OFF;
          end else begin
            if (tmr_q == 24'h000000) begin
              en_q <= en_act; // see R1
            end
            if (slot_end) begin
              // Only ON waits on power-good; other kinds run on time
              if (~is_on | pg_ok) begin // see R2
                tmr_q <= 24'h000000;
                if (last) begin
                  case (kind_q)
                    `PS_K_OFF: begin
                      st_q <= S_OFF;
                      ms_q <= `PS_MS_OFF;
                    end
                    `PS_K_SLP: begin
                      st_q <= S_SLP;
                      ms_q <= `PS_MS_SLEEP;
                    end
                    default: begin
                      st_q <= S_ON;
                      ms_q <= `PS_MS_ON;
                    end
                  endcase
                end else begin
                  slot_q <= rev ? slot_q - 3'h1 : slot_q + 3'h1;
                end
              end
            end else begin
              tmr_q <= tmr_q + 24'h000001;
            end
          end
        end
        default: begin
          st_q <= S_OFF;
          ms_q <= `PS_MS_OFF;
        end
      endcase
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign item_en = en_q;
  assign main_state = ms_q;
  assign seq_fail = seq_fail_q;

endmodule // psts_sequencer

// ---- src/psts_map.vh ----
// Register map, field layout and timing constants of the power-state
// slot sequencer. Definitions only; included by the sequencer module.
`ifndef PSTS_MAP_VH
`define PSTS_MAP_VH

// Register indices; byte address is four times the index
`define PS_IX_CTL 16'h4003
`define PS_IX_STAT 16'h400D
`define PS_IX_ONSRC 16'h400E
`define PS_IX_OFFSRC 16'h400F
`define PS_IX_ONSLOT 16'h4010
`define PS_IX_SLPSLOT 16'h4011
`define PS_IX_SWEN 16'h4012
`define PS_IX_HWSEL 16'h4013

// Control register fields
`define PS_B_SYSON 15
`define PS_B_SLEEP 14
`define PS_F_DLY 11:10
`define PS_B_AONKEEP 0
`define PS_DLY_RST 2'h2
`define PS_DLY_1MS 2'h2
`define PS_DLY_10MS 2'h3

// On/wake source masks
`define PS_OW_TRANS 16'h8000
`define PS_OW_GPIO 16'h0800
`define PS_OW_LOW_SUPPLY_THRESHOLD 16'h0400
`define PS_OW_CHG 16'h0100
`define PS_OW_WDOG 16'h0080
`define PS_OW_SW 16'h0040
`define PS_OW_RTC 16'h0020
`define PS_OW_PIN 16'h0010
`define PS_OW_RST 16'h0002
`define PS_OW_ONC 16'h0832
`define PS_OW_WKC 16'h0DF0

// Off source masks
`define PS_OF_SEQ 16'h1000
`define PS_OF_GPIO 16'h0800
`define PS_OF_SW 16'h0040
`define PS_OF_PIN 16'h0010

// Main state codes
`define PS_MS_OFF 5'h00
`define PS_MS_PROG 5'h0B
`define PS_MS_TRANS 5'h10
`define PS_MS_SLEEP 5'h1C
`define PS_MS_ON 5'h1F

// Items, slots and sequence kinds
`define PS_N_ITEM 10
`define PS_FOURTH_IDX 3
`define PS_AON_IDX 7
`define PS_SLOT_W 3
`define PS_SLOT_FIRST 3'h1
`define PS_SLOT_LAST 3'h5
`define PS_SLOT_NONE 3'h0
`define PS_K_ON 2'h0
`define PS_K_OFF 2'h1
`define PS_K_SLP 2'h2
`define PS_K_WK 2'h3

// Timing
`define PS_MCLK_MHZ 8'd25
`define PS_SLOT_US 24'd2000
`define PS_DLY1_US 24'd1000
`define PS_DLY10_US 24'd10000
`define PS_FAIL_US 26'd2000000

`endif

// ---- tb/psts_seq_assertions.sv ----
// Checker for the slot sequencer: bus handshake, state codes, shutdown.
// Assumes it is bound to psts_sequencer and sees only its ports.
`timescale 1ns/10ps
module psts_seq_assertions #(
  parameter N_ITEM = 10
) (
  // Clock and reset
  input wire mclk,
  input wire rst_b,
  // Bus
  input wire [17:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Power side
  input wire supply_good,
  input wire [N_ITEM-1:0] item_en,
  input wire [4:0] main_state,
  input wire seq_fail
);
  localparam [N_ITEM-1:0] AON_MASK = {{(N_ITEM-8){1'b0}}, 8'h80};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request left unanswered");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  // Slot maps are the only 32-bit wide registers
  a_upper_zero: assert property (!avs_waitrequest && avs_read &&
    avs_address[17:2] != 16'h4010 && avs_address[17:2] != 16'h4011 |->
    avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_state_code: assert property (
    main_state inside {5'h00, 5'h0B, 5'h10, 5'h1C, 5'h1F})
    else $error("illegal main state");
  a_off_quiet: assert property (main_state == 5'h00 |-> (item_en & ~AON_MASK) == 0)
    else $error("item on while off");
  a_fail_off: assert property (seq_fail |-> ##[0:1] (item_en == 0 && main_state == 5'h00))
    else $error("failure did not clear items");
  a_fail_pulse: assert property (seq_fail |=> !seq_fail)
    else $error("failure flag too long");
  a_on_supply: assert property (main_state == 5'h00 && !supply_good |=> main_state != 5'h10)
    else $error("on started without supply");
  a_on_leave: assert property (main_state == 5'h1F |=> main_state inside {5'h1F, 5'h10})
    else $error("left on without transit");
endmodule // psts_seq_assertions

// ---- tb/psts_rail_model.sv ----
// Rail model: each item reports power good a few cycles after enable.
// Assumes items 8 and 9 are logic outputs without a power-good of their own.
`timescale 1ns/10ps
module psts_rail_model #(
  parameter N_ITEM = 10,
  parameter LAT = 3
) (
  input wire mclk,
  input wire [N_ITEM-1:0] item_en,
  input wire [N_ITEM-1:0] stall,
  output logic [N_ITEM-1:0] power_good = '0
);
  logic [N_ITEM-1:0] dly_q [LAT];
  always @(posedge mclk) begin
    dly_q[0] <= item_en;
    for (int i = 1; i < LAT; i++) dly_q[i] <= dly_q[i-1];
    // Stalled rails stay down so a slow or dead start can be commanded
    power_good <= (dly_q[LAT-1] & item_en & ~stall) | {2'b11, {(N_ITEM-2){1'b0}}};
  end
endmodule // psts_rail_model

// ---- tb/tb_psts_sequencer.sv ----
// Testbench of the slot sequencer: register bus tasks and state scenarios.
// Assumes shortened counts: slot 20, delays 10 and 30, failure 400 cycles.
`timescale 1ns/10ps
module tb_psts_sequencer;
  localparam int SLOT = 20;
  logic mclk = 0, rst_b = 0, avs_read = 0, avs_write = 0, supply_good = 0;
  logic [17:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, q;
  logic [8:0] ev = '0;
  logic [9:0] stall = '0, hw_en = '0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, seq_fail;
  wire [9:0] power_good, item_en;
  wire [4:0] main_state;
  int err_count = 0, tests_run = 0, cyc = 0, t;
  always #20 mclk = ~mclk;
  psts_sequencer #(.SLOT_CYC(24'd20), .DLY1_CYC(24'd10), .DLY10_CYC(24'd30),
    .FAIL_CYC(26'd400)) psts_sequencer_inst (.mclk, .rst_b, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .ev_on_pin(ev[0]),
    .ev_on_gpio(ev[1]), .ev_rtc_alarm(ev[2]), .ev_charger(ev[3]), .ev_watchdog(ev[4]),
    .ev_low_supply(ev[5]), .ev_off_pin(ev[6]), .ev_off_gpio(ev[7]), .ev_reset(ev[8]),
    .supply_good, .power_good, .hw_enable_in(hw_en), .item_en, .main_state, .seq_fail);
  psts_rail_model psts_rail_model_inst (.mclk, .item_en, .stall, .power_good);
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the request until waitrequest is sampled low, then frees a cycle
  task automatic bus(input logic w, input logic [15:0] ix, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= {ix, 2'b00};
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    if (n >= 50) chk("bus answer", 0, 1);
    avs_read <= 0;
    avs_write <= 0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [15:0] ix, input logic [31:0] exp, input string what);
    bus(0, ix, 0);
    chk(what, exp, q);
  endtask
  task automatic wait_en(input int i, input logic v);
    t = 0;
    while (item_en[i] !== v && t < 3000) begin
      @(posedge mclk);
      t++;
    end
    if (t >= 3000) chk("enable wait limit", 0, 1);
  endtask
  task automatic wait_st(input logic [4:0] s);
    t = 0;
    while (main_state !== s && t < 3000) begin
      @(posedge mclk);
      t++;
    end
    if (t >= 3000) chk("state wait limit", 0, 1);
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1;
    @(posedge mclk);
    ev[k] <= 0;
    @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict;
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    rd(16'h4003, 32'h0800, "ctl reset");
    rd(16'h400D, 0, "state reset");
    rd(16'h400E, 0, "onsrc reset");
    rd(16'h4020, 0, "unmapped");
    bus(1, 16'h4010, 32'h0300_0151);
    stall <= 10'h002;
    pulse(0);
    repeat (10) @(posedge mclk);
    chk("no supply", 5'h00, main_state);
    supply_good <= 1;
    wait_en(0, 1);
    wait_en(1, 1);
    chk("slot length", SLOT, t);
    repeat (50) @(posedge mclk);
    chk("stretched slot", 0, item_en[8]);
    stall <= 0;
    wait_st(5'h1F);
    chk("on items", 10'h107, item_en);
    rd(16'h400E, 32'h8010, "onsrc pin");
    bus(1, 16'h4012, 32'h117);
    rd(16'h4012, 32'h117, "sw enable");
    bus(1, 16'h4013, 32'h020);
    hw_en <= 10'h020;
    repeat (3) @(posedge mclk);
    chk("hw enable on", 10'h137, item_en);
    hw_en <= 10'h000;
    repeat (3) @(posedge mclk);
    chk("hw enable off", 10'h117, item_en);
    bus(1, 16'h4010, 32'h0300_0055);
    bus(1, 16'h4003, 32'h0C00);
    wait_en(0, 0);
    chk("off delay", 1, t >= 30 && t <= 34);
    chk("off order", 10'h106, item_en);
    wait_en(2, 0);
    chk("off span", 4 * SLOT, t);
    wait_st(5'h00);
    rd(16'h4003, 32'h0C00, "ctl off");
    rd(16'h400F, 32'h0040, "offsrc sw");
    pulse(1);
    wait_st(5'h1F);
    rd(16'h400E, 32'h8800, "onsrc gpio");
    bus(1, 16'h4011, 32'h110);
    bus(1, 16'h4003, 32'hCC00);
    wait_st(5'h1C);
    chk("sleep items", 10'h101, item_en);
    rd(16'h4003, 32'hCC00, "ctl sleep");
    bus(1, 16'h4011, 32'h150);
    pulse(3);
    wait_en(2, 1);
    wait_en(1, 1);
    chk("wake span", 3 * SLOT, t);
    wait_st(5'h1F);
    rd(16'h400E, 32'h0100, "onsrc charger");
    bus(1, 16'h4003, 32'hCC00);
    wait_st(5'h1C);
    pulse(6);
    wait_st(5'h00);
    chk("sleep off fast", 1, t <= 4);
    chk("sleep off items", 0, item_en);
    rd(16'h400F, 32'h0010, "offsrc pin");
    pulse(5);
    repeat (10) @(posedge mclk);
    chk("low supply", 5'h00, main_state);
    stall <= 10'h001;
    pulse(0);
    t = 0;
    while (seq_fail !== 1'b1 && t < 1000) begin
      @(posedge mclk);
      t++;
    end
    chk("fail time", 1, t >= 396 && t <= 404);
    @(posedge mclk);
    chk("fail items", 0, item_en);
    rd(16'h400F, 32'h1000, "offsrc fail");
    stall <= 0;
    pulse(0);
    wait_st(5'h1F);
    bus(1, 16'h4003, 32'h8C01);
    bus(1, 16'h4012, 32'h187);
    pulse(8);
    wait_st(5'h00);
    chk("aon kept", 10'h080, item_en);
    wait_st(5'h1F);
    rd(16'h400E, 32'h8002, "onsrc reset event");
    give_verdict;
  end
endmodule // tb_psts_sequencer
bind psts_sequencer psts_seq_assertions #(.N_ITEM(N_ITEM)) psts_seq_assertions_inst (.mclk,
  .rst_b, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .supply_good,
  .item_en,
  .main_state, .seq_fail);
